// >>> arct_pkg.sv
// Constants shared by the two-timer block: register addresses, field
// positions, values after reset and divider counts.
// Assumes an 8-bit special function register space with byte addresses.
`default_nettype none

package arct_pkg;

  // Register addresses, timer two
  localparam logic [7:0] ADDR_T2_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_T2_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] ADDR_T2_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_T2_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_T2_COUNT_HIGH = 8'hCD;

  // Register addresses, timer three
  localparam logic [7:0] ADDR_T3_CONTROL = 8'h91;
  localparam logic [7:0] ADDR_T3_RELOAD_LOW = 8'h92;
  localparam logic [7:0] ADDR_T3_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] ADDR_T3_COUNT_LOW = 8'h94;
  localparam logic [7:0] ADDR_T3_COUNT_HIGH = 8'h95;

  // Clock scale control register, shared by both timers
  localparam logic [7:0] ADDR_CLOCK_SCALE = 8'h8E;

  // Control register fields
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_XCLK_HI = 1;
  localparam int BIT_XCLK_LO = 0;

  // Clock scale field: timer two low select; then t2 high, t3 low, t3 high
  localparam int BIT_CLK_SEL_BASE = 4;

  // Values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_DIV = 4'h0;
  localparam logic [2:0] RST_OSC_DIV = 3'h0;

  // Divider counts: system clock by 12, oscillators by 8
  localparam logic [3:0] PRESCALE_LAST = 4'hB;
  localparam logic [2:0] OSC_DIV_LAST = 3'h7;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;

endpackage : arct_pkg

`default_nettype wire

// >>> arct_tick_if.sv
// Tick strobes passed from the tick generator to the timer core.
// Assumes every strobe is one system clock wide and on the same clock.
`default_nettype none

interface arct_tick_if;
  logic presc_tick;
  logic [1:0] osc_tick;
  logic [1:0] cmp_tick;

  // Generator side
  modport src (output presc_tick, output osc_tick, output cmp_tick);
  // Timer core side
  modport use_side (input presc_tick, input osc_tick, input cmp_tick);
endinterface : arct_tick_if

`default_nettype wire

// >>> arct_sync2.sv
// Two-stage synchroniser for levels that arrive from other clocks or pins.
// Assumes the inputs may change at any time relative to clk.
`default_nettype none

module arct_sync2 #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage is read by the second stage only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : arct_sync2

`default_nettype wire

// >>> arct_tick_gen.sv
// Tick generator: system clock by 12, oscillator clocks by 8 and
// comparator rising edges, each as a one-cycle strobe.
// Assumes its level inputs are already synchronised to clk.
`default_nettype none

module arct_tick_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Synchronised levels, index 0 for timer two, 1 for timer three
  input wire logic [1:0] osc_lvl,
  input wire logic [1:0] cmp_lvl,
  // Strobes out
  arct_tick_if.src ticks
);

  logic [3:0] presc_ff;
  logic [1:0] osc_prev_ff;
  logic [1:0] cmp_prev_ff;
  logic [2:0] osc_div_ff [2];

  // Free-running prescaler, strobe on the twelfth cycle
  always_ff @(posedge clk) begin
    if (sys_rst || presc_ff == arct_pkg::PRESCALE_LAST) begin
      presc_ff <= arct_pkg::RST_DIV;
    end else begin
      presc_ff <= presc_ff + 4'h1;
    end
  end

  // Edge history of the synchronised levels
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_prev_ff <= 2'h0;
      cmp_prev_ff <= 2'h0;
    end else begin
      osc_prev_ff <= osc_lvl;
      cmp_prev_ff <= cmp_lvl;
    end
  end

  // Count oscillator rising edges; every eighth gives a strobe
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (sys_rst) begin
        osc_div_ff[i] <= arct_pkg::RST_OSC_DIV;
      end else if (osc_lvl[i] && !osc_prev_ff[i]) begin
        osc_div_ff[i] <= osc_div_ff[i] + 3'h1;
      end
    end
  end

  // Registered strobes, one cycle after the causing edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ticks.presc_tick <= 1'b0;
      ticks.osc_tick <= 2'h0;
      ticks.cmp_tick <= 2'h0;
    end else begin
      ticks.presc_tick <= (presc_ff == arct_pkg::PRESCALE_LAST);
      for (int i = 0; i < 2; i++) begin
        ticks.osc_tick[i] <= osc_lvl[i] && !osc_prev_ff[i]
                             && (osc_div_ff[i] == arct_pkg::OSC_DIV_LAST);
        ticks.cmp_tick[i] <= cmp_lvl[i] && !cmp_prev_ff[i];
      end
    end
  end

endmodule : arct_tick_gen

`default_nettype wire

// >>> arct_timers.sv
// Two auto-reload/capture timers behind the special function register port.
// Index 0 of every array is timer two, index 1 is timer three.
// Assumes the core issues single-cycle read and write strobes on clk and
// that interrupt enables come from the interrupt controller on the same clock.
`default_nettype none

module arct_timers (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Interrupt enables from the interrupt controller
  input wire logic t2_irq_enable,
  input wire logic t3_irq_enable,
  // Asynchronous clock and comparator inputs
  input wire logic slow_osc_clk,
  input wire logic ext_osc_clk,
  input wire logic cmp0_out,
  input wire logic cmp1_out,
  // Interrupt requests
  output logic t2_irq,
  output logic t3_irq
);

  // Zero byte for capture-mode wraps and unmapped reads
  localparam logic [7:0] RST_ZERO = arct_pkg::RST_BYTE;

  // Register state
  logic [7:0] ctl_ff [2];
  logic [7:0] cnt_lo_ff [2];
  logic [7:0] cnt_hi_ff [2];
  logic [7:0] rl_lo_ff [2];
  logic [7:0] rl_hi_ff [2];
  logic [7:0] clk_scale_ff;
  logic [7:0] rdata_ff;
  logic [1:0] irq_ff;

  // Next values
  logic [7:0] nxt_ctl [2];
  logic [7:0] nxt_cnt_lo [2];
  logic [7:0] nxt_cnt_hi [2];
  logic [7:0] nxt_rl_lo [2];
  logic [7:0] nxt_rl_hi [2];
  logic [7:0] nxt_rdata;
  logic [1:0] nxt_irq;

  // Per-timer decode and events
  logic [1:0] wr_ctl, wr_lo, wr_hi, wr_rl_lo, wr_rl_hi;
  logic [1:0] tick_lo, tick_hi, cap_evt;
  logic [1:0] lo_inc, hi_inc, lo_wrap, hi_wrap;
  logic [1:0] irq_en;

  logic [3:0] sync_lvl;

  arct_tick_if ticks ();

  // Pins cross into the clock domain before any use
  arct_sync2 #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({cmp1_out, cmp0_out, ext_osc_clk, slow_osc_clk}),
    .sync_out(sync_lvl)
  );

  arct_tick_gen u_ticks (
    .clk(clk),
    .sys_rst(sys_rst),
    .osc_lvl(sync_lvl[1:0]),
    .cmp_lvl(sync_lvl[3:2]),
    .ticks(ticks.src)
  );

  assign irq_en = {t3_irq_enable, t2_irq_enable};

  // Source for one half: system clock, or the one named by the field
  function automatic logic pick_tick(input logic use_sys, input logic [1:0] field,
                                     input logic presc, input logic osc,
                                     input logic cmp);
    if (use_sys) begin
      return 1'b1;
    end else if (!field[0]) begin
      return presc;
    end else if (field[1]) begin
      return cmp;
    end
    return osc;
  endfunction : pick_tick

  // Address of a timer register: the timer two address for t == 0, else the timer three one
  function automatic logic [7:0] taddr(input int t, input logic [7:0] a2,
                                       input logic [7:0] a3);
    return (t == 0) ? a2 : a3;
  endfunction : taddr

  // Write strobes per timer register
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      wr_ctl[i] = sfr_wr && sfr_addr == taddr(i, arct_pkg::ADDR_T2_CONTROL,
                                              arct_pkg::ADDR_T3_CONTROL);
      wr_lo[i] = sfr_wr && sfr_addr == taddr(i, arct_pkg::ADDR_T2_COUNT_LOW,
                                             arct_pkg::ADDR_T3_COUNT_LOW);
      wr_hi[i] = sfr_wr && sfr_addr == taddr(i, arct_pkg::ADDR_T2_COUNT_HIGH,
                                             arct_pkg::ADDR_T3_COUNT_HIGH);
      wr_rl_lo[i] = sfr_wr && sfr_addr == taddr(i, arct_pkg::ADDR_T2_RELOAD_LOW,
                                                arct_pkg::ADDR_T3_RELOAD_LOW);
      wr_rl_hi[i] = sfr_wr && sfr_addr == taddr(i, arct_pkg::ADDR_T2_RELOAD_HIGH,
                                                arct_pkg::ADDR_T3_RELOAD_HIGH);
    end
  end

  // Clock selection and capture events
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      tick_lo[i] = pick_tick(clk_scale_ff[arct_pkg::BIT_CLK_SEL_BASE + 2 * i],
                             ctl_ff[i][arct_pkg::BIT_XCLK_HI:arct_pkg::BIT_XCLK_LO],
                             ticks.presc_tick, ticks.osc_tick[i],
                             ticks.cmp_tick[i]);
      tick_hi[i] = pick_tick(clk_scale_ff[arct_pkg::BIT_CLK_SEL_BASE + 2 * i + 1],
                             ctl_ff[i][arct_pkg::BIT_XCLK_HI:arct_pkg::BIT_XCLK_LO],
                             ticks.presc_tick, ticks.osc_tick[i],
                             ticks.cmp_tick[i]);
      // Comparator edges or every eighth oscillator cycle
      cap_evt[i] = ctl_ff[i][arct_pkg::BIT_CAPTURE_EN]
                   && (ctl_ff[i][arct_pkg::BIT_XCLK_HI] ? ticks.cmp_tick[i]
                                                         : ticks.osc_tick[i]);
    end
  end

  // Increment and wrap detection for both widths
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (ctl_ff[i][arct_pkg::BIT_SPLIT]) begin
        lo_inc[i] = tick_lo[i];
        hi_inc[i] = ctl_ff[i][arct_pkg::BIT_RUN] && tick_hi[i];
        lo_wrap[i] = lo_inc[i] && cnt_lo_ff[i] == arct_pkg::BYTE_ALL_ONES;
        hi_wrap[i] = hi_inc[i] && cnt_hi_ff[i] == arct_pkg::BYTE_ALL_ONES;
      end else begin
        lo_inc[i] = ctl_ff[i][arct_pkg::BIT_RUN] && tick_lo[i];
        lo_wrap[i] = lo_inc[i] && cnt_lo_ff[i] == arct_pkg::BYTE_ALL_ONES;
        hi_inc[i] = lo_wrap[i];
        hi_wrap[i] = lo_wrap[i] && cnt_hi_ff[i] == arct_pkg::BYTE_ALL_ONES;
      end
    end
  end

  // Counter next values; a software write to a byte wins over counting
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      nxt_cnt_lo[i] = cnt_lo_ff[i];
      nxt_cnt_hi[i] = cnt_hi_ff[i];
      if (ctl_ff[i][arct_pkg::BIT_SPLIT]) begin
        // Each half reloads from its own byte
        if (lo_wrap[i]) begin
          nxt_cnt_lo[i] = rl_lo_ff[i];
        end else if (lo_inc[i]) begin
          nxt_cnt_lo[i] = cnt_lo_ff[i] + 8'h01;
        end
        if (hi_wrap[i]) begin
          nxt_cnt_hi[i] = rl_hi_ff[i];
        end else if (hi_inc[i]) begin
          nxt_cnt_hi[i] = cnt_hi_ff[i] + 8'h01;
        end
      end else if (hi_wrap[i]) begin
        // Capture mode keeps the reload pair for captures, so wrap to zero
        if (ctl_ff[i][arct_pkg::BIT_CAPTURE_EN]) begin
          nxt_cnt_lo[i] = RST_ZERO;
          nxt_cnt_hi[i] = RST_ZERO;
        end else begin
          nxt_cnt_lo[i] = rl_lo_ff[i];
          nxt_cnt_hi[i] = rl_hi_ff[i];
        end
      end else if (lo_inc[i]) begin
        nxt_cnt_lo[i] = cnt_lo_ff[i] + 8'h01;
        nxt_cnt_hi[i] = cnt_hi_ff[i] + {7'h00, hi_inc[i]};
      end
      if (wr_lo[i]) begin
        nxt_cnt_lo[i] = sfr_wdata;
      end
      if (wr_hi[i]) begin
        nxt_cnt_hi[i] = sfr_wdata;
      end
    end
  end

  // Reload pair: a capture wins over a software write in the same cycle
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      nxt_rl_lo[i] = wr_rl_lo[i] ? sfr_wdata : rl_lo_ff[i];
      nxt_rl_hi[i] = wr_rl_hi[i] ? sfr_wdata : rl_hi_ff[i];
      if (cap_evt[i]) begin
        nxt_rl_lo[i] = cnt_lo_ff[i];
        nxt_rl_hi[i] = cnt_hi_ff[i];
      end
    end
  end

  // Control and sticky flags; a hardware set wins over a software clear
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      nxt_ctl[i] = wr_ctl[i] ? sfr_wdata : ctl_ff[i];
      nxt_ctl[i][arct_pkg::BIT_HIGH_FLAG] = nxt_ctl[i][arct_pkg::BIT_HIGH_FLAG]
                                            | hi_wrap[i] | cap_evt[i];
      nxt_ctl[i][arct_pkg::BIT_LOW_FLAG] = nxt_ctl[i][arct_pkg::BIT_LOW_FLAG]
                                           | lo_wrap[i];
    end
  end

  // Interrupt request is a level from the sticky flags, so none is missed
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      nxt_irq[i] = irq_en[i] && (ctl_ff[i][arct_pkg::BIT_HIGH_FLAG]
                   || (ctl_ff[i][arct_pkg::BIT_LOW_IRQ_EN]
                       && ctl_ff[i][arct_pkg::BIT_LOW_FLAG]));
    end
  end

  // Read multiplexer; unmapped addresses read as zero
  always_comb begin
    nxt_rdata = RST_ZERO;
    if (sfr_addr == arct_pkg::ADDR_CLOCK_SCALE) begin
      nxt_rdata = clk_scale_ff;
    end
    for (int i = 0; i < 2; i++) begin
      if (sfr_addr == taddr(i, arct_pkg::ADDR_T2_CONTROL, arct_pkg::ADDR_T3_CONTROL)) begin
        nxt_rdata = ctl_ff[i];
      end
      if (sfr_addr == taddr(i, arct_pkg::ADDR_T2_COUNT_LOW,
                            arct_pkg::ADDR_T3_COUNT_LOW)) begin
        nxt_rdata = cnt_lo_ff[i];
      end
      if (sfr_addr == taddr(i, arct_pkg::ADDR_T2_COUNT_HIGH,
                            arct_pkg::ADDR_T3_COUNT_HIGH)) begin
        nxt_rdata = cnt_hi_ff[i];
      end
      if (sfr_addr == taddr(i, arct_pkg::ADDR_T2_RELOAD_LOW,
                            arct_pkg::ADDR_T3_RELOAD_LOW)) begin
        nxt_rdata = rl_lo_ff[i];
      end
      if (sfr_addr == taddr(i, arct_pkg::ADDR_T2_RELOAD_HIGH,
                            arct_pkg::ADDR_T3_RELOAD_HIGH)) begin
        nxt_rdata = rl_hi_ff[i];
      end
    end
  end

  // Timer registers
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (sys_rst) begin
        ctl_ff[i] <= arct_pkg::RST_BYTE;
        cnt_lo_ff[i] <= arct_pkg::RST_BYTE;
        cnt_hi_ff[i] <= arct_pkg::RST_BYTE;
        rl_lo_ff[i] <= arct_pkg::RST_BYTE;
        rl_hi_ff[i] <= arct_pkg::RST_BYTE;
      end else begin
        ctl_ff[i] <= nxt_ctl[i];
        cnt_lo_ff[i] <= nxt_cnt_lo[i];
        cnt_hi_ff[i] <= nxt_cnt_hi[i];
        rl_lo_ff[i] <= nxt_rl_lo[i];
        rl_hi_ff[i] <= nxt_rl_hi[i];
      end
    end
  end

  // Clock scale register, written whole
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_scale_ff <= arct_pkg::RST_BYTE;
    end else if (sfr_wr && sfr_addr == arct_pkg::ADDR_CLOCK_SCALE) begin
      clk_scale_ff <= sfr_wdata;
    end
  end

  // Read data held until the next read strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= arct_pkg::RST_BYTE;
    end else if (sfr_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Interrupt request flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_ff <= 2'h0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign t2_irq = irq_ff[0];
  assign t3_irq = irq_ff[1];

endmodule : arct_timers

`default_nettype wire

// >>> arct_properties.sv
// Checker for the two-timer block, watching only its top-level ports.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none

module arct_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Interrupts
  input wire logic t2_irq_enable,
  input wire logic t3_irq_enable,
  input wire logic t2_irq,
  input wire logic t3_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Requests start low after every reset release
  irq_reset_low_a:
    assert property ($fell(sys_rst) |-> !t2_irq && !t3_irq)
    else $error("interrupt high at reset release");
  // Read data only moves on a read strobe
  rdata_hold_a:
    assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a:
    assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
    else $error("unmapped address read nonzero");
  scale_readback_a:
    assert property (sfr_wr && sfr_addr == arct_pkg::ADDR_CLOCK_SCALE ##1 !sfr_wr
      ##1 sfr_rd && !sfr_wr && sfr_addr == arct_pkg::ADDR_CLOCK_SCALE
      |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("clock scale readback differs");
  // Flags may be set by hardware meanwhile, so only the mode bits
  t2_ctrl_readback_a:
    assert property (sfr_wr && sfr_addr == arct_pkg::ADDR_T2_CONTROL ##1 !sfr_wr
      ##1 sfr_rd && !sfr_wr && sfr_addr == arct_pkg::ADDR_T2_CONTROL
      |=> sfr_rdata[5:0] == $past(sfr_wdata[5:0], 3))
    else $error("timer two mode bits readback differs");
  t2_irq_gate_a:
    assert property (!t2_irq_enable |=> !t2_irq)
    else $error("timer two request while disabled");
  t2_flag_irq_a:
    assert property (sfr_wr && sfr_addr == arct_pkg::ADDR_T2_CONTROL && sfr_wdata[7]
      && t2_irq_enable ##1 !sfr_wr && t2_irq_enable |=> t2_irq)
    else $error("timer two high flag gave no request");
  t3_low_irq_a:
    assert property (sfr_wr && sfr_addr == arct_pkg::ADDR_T3_CONTROL && sfr_wdata[6]
      && sfr_wdata[5] && t3_irq_enable ##1 !sfr_wr && t3_irq_enable |=> t3_irq)
    else $error("timer three low flag gave no request");
  // Second clear lands with the run bit already off, so no new set
  t2_clear_quiet_a:
    assert property (sfr_wr && sfr_addr == arct_pkg::ADDR_T2_CONTROL && sfr_wdata == 8'h00
      ##2 sfr_wr && sfr_addr == arct_pkg::ADDR_T2_CONTROL && sfr_wdata == 8'h00
      ##1 !sfr_wr |=> !t2_irq)
    else $error("timer two request after flags cleared");

  // Main scenarios reached
  cover property ($rose(t2_irq));
  cover property ($rose(t3_irq));
  cover property (sfr_rd && sfr_addr == arct_pkg::ADDR_T3_RELOAD_LOW);
endmodule : arct_properties

bind arct_timers arct_properties arct_properties_inst (
  .clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
  .t2_irq_enable, .t3_irq_enable, .t2_irq, .t3_irq
);

`default_nettype wire

// >>> arct_osc_model.sv
// Oscillator sources standing at the far side of the timer clock pins.
// Assumes clk is the system clock; a stopped source rests low.
`default_nettype none

module arct_osc_model #(
  parameter int HALF = 5
) (
  // Reference clock
  input wire logic clk,
  // Run controls, bit 0 slow oscillator, bit 1 external oscillator
  input wire logic [1:0] osc_run,
  // Oscillator pins
  output logic slow_osc_clk,
  output logic ext_osc_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic [1:0] osc_q;

  // Toggle every HALF cycles off the falling edge; masked when stopped
  initial begin
    cnt = 0;
    osc_q = 2'h0;
    forever begin
      @(negedge clk);
      cnt = (cnt + 1) % HALF;
      if (cnt == 0) begin
        osc_q = ~osc_q & osc_run;
      end
    end
  end
  assign slow_osc_clk = osc_q[0];
  assign ext_osc_clk = osc_q[1];
endmodule : arct_osc_model

`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the two-timer block.
// Assumes register strobes one cycle wide, driven at the falling edge.
`default_nettype none

`define CHECK(name, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("Error %s expected %h seen %h", name, exp, got); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, sfr_wr, sfr_rd, t2_irq_enable, t3_irq_enable;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic slow_osc_clk, ext_osc_clk, cmp0_out, cmp1_out, t2_irq, t3_irq;
  logic [1:0] osc_run;
  int fail_count = 0;
  int samples_checked = 0;

  arct_timers arct_timers_inst (.clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .t2_irq_enable, .t3_irq_enable, .slow_osc_clk, .ext_osc_clk, .cmp0_out,
    .cmp1_out, .t2_irq, .t3_irq);
  arct_osc_model arct_osc_model_inst (.clk, .osc_run, .slow_osc_clk, .ext_osc_clk);

  // 50 ns system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    `CHECK(name, exp, d)
  endtask : rd_chk

  // Bounded wait; running out ends the run as a mismatch
  task automatic wait_irq(input bit t3);
    int n;
    n = 0;
    while ((t3 ? t3_irq : t2_irq) !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        fail_count++;
        $display("Error irq wait expected 1 seen 0");
        conclude();
      end
    end
  endtask : wait_irq

  task automatic s_registers();
    rd_chk("t2 control reset", arct_pkg::ADDR_T2_CONTROL, arct_pkg::RST_BYTE);
    rd_chk("t3 count high reset", arct_pkg::ADDR_T3_COUNT_HIGH, arct_pkg::RST_BYTE);
    wr(8'h00, 8'h5A);
    rd_chk("unmapped", 8'h00, 8'h00);
    wr(arct_pkg::ADDR_CLOCK_SCALE, 8'hA5);
    rd_chk("clock scale", arct_pkg::ADDR_CLOCK_SCALE, 8'hA5);
    wr(arct_pkg::ADDR_T3_CONTROL, 8'h60);
    repeat (3) @(negedge clk);
    `CHECK("t3 low irq", 1'b1, t3_irq)
    wr(arct_pkg::ADDR_T3_CONTROL, 8'h00);
    wr(arct_pkg::ADDR_T3_CONTROL, 8'h00);
    repeat (3) @(negedge clk);
    `CHECK("t3 irq cleared", 1'b0, t3_irq)
  endtask : s_registers

  // Full wrap lands on the same edge as the stop write
  task automatic s_t2_wide();
    logic [7:0] d;
    wr(arct_pkg::ADDR_CLOCK_SCALE, 8'h10);
    wr(arct_pkg::ADDR_T2_RELOAD_LOW, 8'h34);
    wr(arct_pkg::ADDR_T2_RELOAD_HIGH, 8'h12);
    wr(arct_pkg::ADDR_T2_COUNT_LOW, 8'hFE);
    wr(arct_pkg::ADDR_T2_COUNT_HIGH, 8'hFF);
    wr(arct_pkg::ADDR_T2_CONTROL, 8'h04);
    wr(arct_pkg::ADDR_T2_CONTROL, 8'h00);
    rd_chk("t2 count low", arct_pkg::ADDR_T2_COUNT_LOW, 8'h34);
    rd_chk("t2 count high", arct_pkg::ADDR_T2_COUNT_HIGH, 8'h12);
    rd(arct_pkg::ADDR_T2_CONTROL, d);
    `CHECK("t2 high flag", 8'h80, d & 8'hBF)
    `CHECK("t2 irq", 1'b1, t2_irq)
    // Software set of the high flag keeps the request up
    wr(arct_pkg::ADDR_T2_CONTROL, 8'h80);
    wr(arct_pkg::ADDR_T2_CONTROL, 8'h00);
    wr(arct_pkg::ADDR_T2_CONTROL, 8'h00);
    repeat (3) @(negedge clk);
    `CHECK("t2 irq cleared", 1'b0, t2_irq)
  endtask : s_t2_wide

  task automatic s_t2_split();
    wr(arct_pkg::ADDR_CLOCK_SCALE, 8'h30);
    wr(arct_pkg::ADDR_T2_RELOAD_LOW, 8'hF0);
    wr(arct_pkg::ADDR_T2_RELOAD_HIGH, 8'hE0);
    wr(arct_pkg::ADDR_T2_COUNT_LOW, 8'hFF);
    wr(arct_pkg::ADDR_T2_COUNT_HIGH, 8'hFF);
    wr(arct_pkg::ADDR_T2_CONTROL, 8'h28);
    rd_chk("split low flag", arct_pkg::ADDR_T2_CONTROL, 8'h68);
    rd_chk("split high idle", arct_pkg::ADDR_T2_COUNT_HIGH, 8'hFF);
    `CHECK("split low irq", 1'b1, t2_irq)
    wr(arct_pkg::ADDR_T2_CONTROL, 8'h2C);
    rd_chk("split high reload", arct_pkg::ADDR_T2_COUNT_HIGH, 8'hE0);
    rd_chk("split high flag", arct_pkg::ADDR_T2_CONTROL, 8'hAC);
    wr(arct_pkg::ADDR_T2_CONTROL, 8'h00);
    wr(arct_pkg::ADDR_T2_CONTROL, 8'h00);
  endtask : s_t2_split

  // Comparator edges, divide-by-12 over 120 cycles, oscillator/8 over 160
  task automatic s_t2_sources();
    logic [7:0] a1, a2;
    t2_irq_enable = 1'b0;
    osc_run = 2'b01;
    wr(arct_pkg::ADDR_CLOCK_SCALE, 8'h00);
    wr(arct_pkg::ADDR_T2_COUNT_LOW, 8'h00);
    wr(arct_pkg::ADDR_T2_COUNT_HIGH, 8'h00);
    wr(arct_pkg::ADDR_T2_CONTROL, 8'h07);
    repeat (3) begin
      @(negedge clk);
      cmp0_out = 1'b1;
      repeat (4) @(negedge clk);
      cmp0_out = 1'b0;
      repeat (3) @(negedge clk);
    end
    repeat (6) @(negedge clk);
    rd_chk("comparator count", arct_pkg::ADDR_T2_COUNT_LOW, 8'h03);
    wr(arct_pkg::ADDR_T2_CONTROL, 8'h04);
    rd(arct_pkg::ADDR_T2_COUNT_LOW, a1);
    repeat (118) @(negedge clk);
    rd(arct_pkg::ADDR_T2_COUNT_LOW, a2);
    `CHECK("prescaled ticks", 8'h0A, a2 - a1)
    wr(arct_pkg::ADDR_T2_CONTROL, 8'h05);
    rd(arct_pkg::ADDR_T2_COUNT_LOW, a1);
    repeat (158) @(negedge clk);
    rd(arct_pkg::ADDR_T2_COUNT_LOW, a2);
    `CHECK("oscillator ticks", 8'h02, a2 - a1)
    wr(arct_pkg::ADDR_T2_CONTROL, 8'h00);
  endtask : s_t2_sources

  // Two captures of the external oscillator, 8 periods of 10 cycles apart
  task automatic s_t3_capture();
    logic [7:0] lo1, hi1, lo2, hi2;
    wr(arct_pkg::ADDR_CLOCK_SCALE, 8'h40);
    wr(arct_pkg::ADDR_T3_CONTROL, 8'h14);
    osc_run = 2'b10;
    wait_irq(1'b1);
    rd(arct_pkg::ADDR_T3_RELOAD_LOW, lo1);
    rd(arct_pkg::ADDR_T3_RELOAD_HIGH, hi1);
    wr(arct_pkg::ADDR_T3_CONTROL, 8'h14);
    repeat (3) @(negedge clk);
    wait_irq(1'b1);
    rd(arct_pkg::ADDR_T3_RELOAD_LOW, lo2);
    rd(arct_pkg::ADDR_T3_RELOAD_HIGH, hi2);
    `CHECK("capture period", 16'h0050, {hi2, lo2} - {hi1, lo1})
    osc_run = 2'b00;
    // Comparator rising edges 20 cycles apart
    wr(arct_pkg::ADDR_T3_CONTROL, 8'h16);
    cmp1_out = 1'b1;
    repeat (6) @(negedge clk);
    rd(arct_pkg::ADDR_T3_RELOAD_LOW, lo1);
    rd(arct_pkg::ADDR_T3_RELOAD_HIGH, hi1);
    cmp1_out = 1'b0;
    repeat (10) @(negedge clk);
    cmp1_out = 1'b1;
    repeat (6) @(negedge clk);
    rd(arct_pkg::ADDR_T3_RELOAD_LOW, lo2);
    rd(arct_pkg::ADDR_T3_RELOAD_HIGH, hi2);
    `CHECK("comparator period", 16'h0014, {hi2, lo2} - {hi1, lo1})
    cmp1_out = 1'b0;
    wr(arct_pkg::ADDR_T3_CONTROL, 8'h00);
  endtask : s_t3_capture

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    t2_irq_enable = 1'b1;
    t3_irq_enable = 1'b1;
    cmp0_out = 1'b0;
    cmp1_out = 1'b0;
    osc_run = 2'b00;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    s_registers();
    s_t2_wide();
    s_t2_split();
    s_t2_sources();
    s_t3_capture();
    conclude();
  end
endmodule : testbench

`default_nettype wire
